// ===== src/level_sync.v
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser for a group of independent level inputs;
// a multi-bit group is only safe here because the levels are static
module level_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire core_clk,
    input wire nrst,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    // first stage feeds only the second stage
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RESET_VALUE;
            stable_q <= RESET_VALUE;
        end else begin
            meta_q <= asyncIn;
            stable_q <= meta_q;
        end
    end

    assign syncOut = stable_q;

endmodule

`default_nettype wire

// ===== src/mode_strap_config_latch.v
`timescale 1ns/1ns
`default_nettype none
`include "strap_config_defines.vh"

module mode_strap_config_latch #(
    parameter [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
) (
    input wire core_clk,
    input wire nrst,
    // level indices from the strap front ends
    input wire [1:0] firstStrapInput,
    input wire [2:0] secondStrapInput,
    // serial control bus, open drain
    input wire sclIn,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    // resolved configuration
    output wire displayIdSourceSelect,
    output wire auxAudioSelect,
    output wire externalControllerOverride,
    output wire cableKindSelect,
    output wire remoteDisplayIdLoad,
    output wire [7:0] remoteTableAddr,
    output wire configLoaded
);

    // bus engine states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_OFFSET = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_RDATA = 3'h4;
    localparam [2:0] ST_ACK = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    wire [1:0] firstLevel;
    wire [2:0] secondLevel;
    wire sclSync;
    wire sdaSync;

    reg [7:0] bridgeControl_q;
    reg [7:0] bridgeConfig_q;
    reg [7:0] dualLinkControl_q;
    reg [7:0] remoteAddr_q;
    reg [1:0] settleCnt_q;
    reg captured_q;

    reg sclPrev_q;
    reg sdaPrev_q;
    reg [2:0] state_q;
    reg [2:0] afterAck_q;
    reg [3:0] bitCnt_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg ackDrive_q;
    reg sdaOe_q;
    reg masterAck_q;
    reg writeStrobe_q;
    reg [7:0] writeAddr_q;
    reg [7:0] writeData_q;

    wire sclRise;
    wire sclFall;
    wire startSeen;
    wire stopSeen;
    wire [7:0] shiftNext;
    wire [7:0] readByte;

    // register read decode; unmapped offsets read as a fixed value
    function [7:0] readMux;
        input [7:0] offset;
        input [7:0] ctl;
        input [7:0] cfg;
        input [7:0] dual;
        input [7:0] rem;
        begin
            case (offset)
                `BRIDGE_CONTROL_OFFSET: readMux = ctl;
                `BRIDGE_CONFIGURATION_OFFSET: readMux = cfg;
                `DUAL_LINK_CONTROL_ONE_OFFSET: readMux = dual;
                `REMOTE_ID_ADDR_OFFSET: readMux = rem;
                default: readMux = `UNMAPPED_READ_VALUE;
            endcase
        end
    endfunction

    // strap levels come from analog front ends, so they are resynchronised
    level_sync #(
        .WIDTH(5),
        .RESET_VALUE(5'h00)
    ) strapSync (
        .core_clk(core_clk),
        .nrst(nrst),
        .asyncIn({secondStrapInput, firstStrapInput}),
        .syncOut({secondLevel, firstLevel})
    );

    // bus lines idle high, so the synchronisers reset high to avoid a false start
    level_sync #(
        .WIDTH(2),
        .RESET_VALUE(2'h3)
    ) busSync (
        .core_clk(core_clk),
        .nrst(nrst),
        .asyncIn({sclIn, sdaIn}),
        .syncOut({sclSync, sdaSync})
    );

    // settle counter: the strap synchroniser needs its stages filled before capture
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            settleCnt_q <= 2'h0;
            captured_q <= 1'b0;
        end else if (!captured_q) begin
            if (settleCnt_q == `STRAP_SETTLE_CYCLES) begin
                captured_q <= 1'b1; // one-shot, never rearmed until reset
            end else begin
                settleCnt_q <= settleCnt_q + 2'h1;
            end
        end
    end

    // configuration registers: strap capture once, then software owns the fields;
    // a bus write in the capture cycle still wins, so software is never undone
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bridgeControl_q <= `BRIDGE_CONTROL_RESET;
            bridgeConfig_q <= `BRIDGE_CONFIGURATION_RESET;
            dualLinkControl_q <= `DUAL_LINK_CONTROL_ONE_RESET;
            remoteAddr_q <= `REMOTE_ID_ADDR_RESET; // remote table default address
        end else begin
            if (!captured_q && settleCnt_q == `STRAP_SETTLE_CYCLES) begin
                // lowest to highest level maps to pairs 00..11
                bridgeControl_q[`DISPLAY_ID_SOURCE_BIT] <= firstLevel[1];
                bridgeConfig_q[`AUX_AUDIO_BIT] <= firstLevel[0];
                // eight levels map to codes 000..111 in binary order
                bridgeConfig_q[`OUTSIDE_CONTROLLER_BIT] <= secondLevel[2];
                dualLinkControl_q[`CABLE_KIND_BIT] <= secondLevel[1];
                bridgeConfig_q[`REMOTE_ID_LOAD_BIT] <= secondLevel[0];
            end
            if (writeStrobe_q) begin
                // whole-byte writes override the strapped fields
                if (writeAddr_q == `BRIDGE_CONTROL_OFFSET) begin
                    bridgeControl_q <= writeData_q;
                end
                if (writeAddr_q == `BRIDGE_CONFIGURATION_OFFSET) begin
                    bridgeConfig_q <= writeData_q;
                end
                if (writeAddr_q == `DUAL_LINK_CONTROL_ONE_OFFSET) begin
                    dualLinkControl_q <= writeData_q;
                end
                if (writeAddr_q == `REMOTE_ID_ADDR_OFFSET) begin
                    remoteAddr_q <= writeData_q; // table address may be moved
                end
            end
        end
    end

    // bus line history for edge and start/stop detection
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclSync;
            sdaPrev_q <= sdaSync;
        end
    end

    assign sclRise = sclSync & ~sclPrev_q;
    assign sclFall = ~sclSync & sclPrev_q;
    assign startSeen = sclSync & sclPrev_q & sdaPrev_q & ~sdaSync;
    assign stopSeen = sclSync & sclPrev_q & ~sdaPrev_q & sdaSync;
    assign shiftNext = {shift_q[6:0], sdaSync};
    assign readByte = readMux(ptr_q, bridgeControl_q, bridgeConfig_q, dualLinkControl_q, remoteAddr_q);

    // serial control bus target: address, offset pointer, auto-increment data
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            afterAck_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            ackDrive_q <= 1'b0;
            sdaOe_q <= 1'b0;
            masterAck_q <= 1'b0;
            writeStrobe_q <= 1'b0;
            writeAddr_q <= 8'h00;
            writeData_q <= 8'h00;
        end else begin
            writeStrobe_q <= 1'b0;
            if (startSeen) begin
                // a repeated start also lands here and restarts addressing
                state_q <= ST_ADDR;
                bitCnt_q <= 4'h0;
                ackDrive_q <= 1'b0;
                sdaOe_q <= 1'b0;
            end else if (stopSeen) begin
                state_q <= ST_IDLE;
                ackDrive_q <= 1'b0;
                sdaOe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sdaOe_q <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (sclRise) begin
                            shift_q <= shiftNext;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'h7) begin
                                if (shiftNext[7:1] == TARGET_ADDR) begin
                                    state_q <= ST_ACK;
                                    afterAck_q <= shiftNext[0] ? ST_RDATA : ST_OFFSET;
                                end else begin
                                    // another target on the bus: stay silent until the next start
                                    state_q <= ST_IDLE;
                                end
                            end
                        end
                    end
                    ST_OFFSET: begin
                        if (sclRise) begin
                            shift_q <= shiftNext;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'h7) begin
                                ptr_q <= shiftNext;
                                state_q <= ST_ACK;
                                afterAck_q <= ST_WDATA;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sclRise) begin
                            shift_q <= shiftNext;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'h7) begin
                                writeStrobe_q <= 1'b1;
                                writeAddr_q <= ptr_q;
                                writeData_q <= shiftNext;
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= ST_ACK;
                                afterAck_q <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        // pull low from the eighth falling edge to the ninth
                        if (sclFall) begin
                            if (!ackDrive_q) begin
                                ackDrive_q <= 1'b1;
                                sdaOe_q <= 1'b1;
                            end else begin
                                ackDrive_q <= 1'b0;
                                state_q <= afterAck_q;
                                if (afterAck_q == ST_RDATA) begin
                                    shift_q <= readByte;
                                    sdaOe_q <= ~readByte[7];
                                    bitCnt_q <= 4'h1;
                                end else begin
                                    sdaOe_q <= 1'b0;
                                    bitCnt_q <= 4'h0;
                                end
                            end
                        end
                    end
                    ST_RDATA: begin
                        // msb first; a zero is a driven low, a one is released
                        if (sclFall) begin
                            if (bitCnt_q == 4'h8) begin
                                sdaOe_q <= 1'b0;
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= ST_RACK;
                            end else begin
                                sdaOe_q <= ~shift_q[6];
                                shift_q <= {shift_q[6:0], 1'b0};
                                bitCnt_q <= bitCnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (sclRise) begin
                            masterAck_q <= ~sdaSync;
                        end
                        if (sclFall) begin
                            if (masterAck_q) begin
                                shift_q <= readByte;
                                sdaOe_q <= ~readByte[7];
                                bitCnt_q <= 4'h1;
                                state_q <= ST_RDATA;
                            end else begin
                                // controller said no more; wait for stop or start
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        sdaOe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: the pin is only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_q;

    // field views; 0 searches remote then internal copy, 1 uses local table
    assign displayIdSourceSelect = bridgeControl_q[`DISPLAY_ID_SOURCE_BIT];
    // 0 plain HDMI audio, 1 adds the aux channel
    assign auxAudioSelect = bridgeConfig_q[`AUX_AUDIO_BIT];
    // 1 hands protection and input control to the bus pins
    assign externalControllerOverride = bridgeConfig_q[`OUTSIDE_CONTROLLER_BIT];
    // 0 twisted pair, 1 coaxial
    assign cableKindSelect = dualLinkControl_q[`CABLE_KIND_BIT];
    // 1 copies a found remote table into the internal copy
    assign remoteDisplayIdLoad = bridgeConfig_q[`REMOTE_ID_LOAD_BIT];
    assign remoteTableAddr = remoteAddr_q;
    assign configLoaded = captured_q;

endmodule

`default_nettype wire

// ===== src/strap_config_defines.vh
`ifndef STRAP_CONFIG_DEFINES_VH
`define STRAP_CONFIG_DEFINES_VH

// register offsets on the serial control bus
`define BRIDGE_CONTROL_OFFSET 8'h4F
`define BRIDGE_CONFIGURATION_OFFSET 8'h54
`define DUAL_LINK_CONTROL_ONE_OFFSET 8'h5B
`define REMOTE_ID_ADDR_OFFSET 8'h03

// field positions
`define DISPLAY_ID_SOURCE_BIT 0
`define AUX_AUDIO_BIT 1
`define REMOTE_ID_LOAD_BIT 5
`define OUTSIDE_CONTROLLER_BIT 7
`define CABLE_KIND_BIT 7

// reset values and the value read at unmapped offsets
`define BRIDGE_CONTROL_RESET 8'h00
`define BRIDGE_CONFIGURATION_RESET 8'h00
`define DUAL_LINK_CONTROL_ONE_RESET 8'h00
`define REMOTE_ID_ADDR_RESET 8'hA0
`define UNMAPPED_READ_VALUE 8'h00

// bus target address and strap settle time after reset release
`define TARGET_ADDR_DEFAULT 7'h0C
`define STRAP_SETTLE_CYCLES 2'h3
`define SYNC_STAGES 2

`endif

// ===== verif/strap_config_properties.sv
`timescale 1ns/1ns
`default_nettype none

module strap_config_properties (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] firstStrapInput,
    input wire logic [2:0] secondStrapInput,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic displayIdSourceSelect,
    input wire logic auxAudioSelect,
    input wire logic externalControllerOverride,
    input wire logic cableKindSelect,
    input wire logic remoteDisplayIdLoad,
    input wire logic [7:0] remoteTableAddr,
    input wire logic configLoaded
);
    wire [12:0] fieldVec;

    // every software-visible setting in one vector
    assign fieldVec = {displayIdSourceSelect, auxAudioSelect, externalControllerOverride,
        cableKindSelect, remoteDisplayIdLoad, remoteTableAddr};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // flag reads low at the four edges after release (two sync, settle, capture); it shows at the fifth
    sequence waitCapture;
        !configLoaded [*4];
    endsequence
    sequence loadDone;
        configLoaded;
    endsequence

    chk_capture_delay: assert property ($rose(nrst) |-> waitCapture ##1 loadDone)
        else $error("strap capture not seen at the expected edge");
    chk_display_capture: assert property ($rose(configLoaded) |-> displayIdSourceSelect == firstStrapInput[1])
        else $error("display source field differs from strap");
    chk_audio_capture: assert property ($rose(configLoaded) |-> auxAudioSelect == firstStrapInput[0])
        else $error("audio field differs from strap");
    chk_override_capture: assert property ($rose(configLoaded) |-> externalControllerOverride == secondStrapInput[2])
        else $error("override field differs from strap");
    chk_cable_capture: assert property ($rose(configLoaded) |-> cableKindSelect == secondStrapInput[1])
        else $error("cable field differs from strap");
    chk_remote_capture: assert property ($rose(configLoaded) |-> remoteDisplayIdLoad == secondStrapInput[0])
        else $error("remote load field differs from strap");
    chk_loaded_stays: assert property (configLoaded |=> configLoaded)
        else $error("loaded flag dropped without reset");
    chk_addr_default: assert property ($rose(nrst) |-> (remoteTableAddr == 8'hA0) throughout waitCapture)
        else $error("remote table address not at its default");
    // with the bus clock low long enough no write can land, so straps alone must not move fields
    chk_quiet_bus_hold: assert property ((!sclIn) [*8] ##0 $past(configLoaded) |-> $stable(fieldVec))
        else $error("fields changed without bus traffic");
endmodule

`default_nettype wire

// ===== verif/strap_network_model.sv
`timescale 1ns/1ns
`default_nettype none

// divider networks on the two strap pins; a row picks one ratio, lowest first,
// and the front end reports that row as a level index
module strap_network_model (
    input wire logic [1:0] firstRow,
    input wire logic [2:0] secondRow,
    output logic [1:0] firstLevel,
    output logic [2:0] secondLevel
);
    // static resistors, so the level never moves while a row is held
    assign firstLevel = firstRow;
    assign secondLevel = secondRow;
endmodule

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] firstRow = 2'h0;
    logic [2:0] secondRow = 3'h0;
    logic scl = 1'b1;
    logic sda = 1'b1;
    wire [1:0] firstLevel;
    wire [2:0] secondLevel;
    wire sdaOut, sdaOe, dispSel, audSel, extOvr, cabSel, remLoad, loaded;
    wire [7:0] remAddr;
    wire sdaLine;
    wire [7:0] fields;
    int miscompares = 0;
    int n_checks = 0;

    // open-drain wire with pull-up: low if either side pulls
    assign sdaLine = sda & (sdaOe ? sdaOut : 1'b1);
    assign fields = {3'h0, dispSel, audSel, extOvr, cabSel, remLoad};

    strap_network_model strap_network_model_inst (.firstRow(firstRow), .secondRow(secondRow),
        .firstLevel(firstLevel), .secondLevel(secondLevel));

    mode_strap_config_latch mode_strap_config_latch_inst (.core_clk(core_clk), .nrst(nrst),
        .firstStrapInput(firstLevel), .secondStrapInput(secondLevel), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .displayIdSourceSelect(dispSel), .auxAudioSelect(audSel),
        .externalControllerOverride(extOvr), .cableKindSelect(cabSel), .remoteDisplayIdLoad(remLoad),
        .remoteTableAddr(remAddr), .configLoaded(loaded));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic hp;
        repeat (8) @(negedge core_clk);
    endtask

    // data moves one cycle after the clock falls, so it never races the clock edge
    task automatic bitOut(input logic b, output logic s);
        @(negedge core_clk);
        sda = b;
        hp;
        scl = 1'b1;
        hp;
        s = sdaLine;
        scl = 1'b0;
    endtask

    task automatic busStart;
        @(negedge core_clk);
        sda = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda = 1'b0;
        hp;
        scl = 1'b0;
    endtask

    task automatic busStop;
        @(negedge core_clk);
        sda = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda = 1'b1;
        hp;
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(b[i], s);
        end
        bitOut(1'b1, s);
        ack = ~s;
    endtask

    task automatic recvByte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bitOut(1'b1, s);
            v = {v[6:0], s};
        end
        bitOut(nack, s);
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] data);
        logic a;
        busStart;
        sendByte(8'h18, a);
        chk({7'h00, a}, 8'h01);
        sendByte(off, a);
        sendByte(data, a);
        chk({7'h00, a}, 8'h01);
        busStop;
    endtask

    task automatic rd(input logic [7:0] off, output logic [7:0] v);
        logic a;
        busStart;
        sendByte(8'h18, a);
        sendByte(off, a);
        busStart;
        sendByte(8'h19, a);
        chk({7'h00, a}, 8'h01);
        recvByte(1'b1, v);
        busStop;
    endtask

    task automatic doReset(input logic [1:0] f, input logic [2:0] s);
        firstRow = f;
        secondRow = s;
        nrst = 1'b0;
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        for (int k = 0; k < 20 && loaded !== 1'b1; k++) begin
            @(negedge core_clk);
        end
        chk({7'h00, loaded}, 8'h01);
    endtask

    // every level of both straps, each read back over the bus
    task automatic t_capture;
        logic [1:0] f;
        logic [2:0] s;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            f = ~i[1:0];
            s = i[2:0];
            doReset(f, s);
            chk(fields, {3'h0, f, s});
            chk(remAddr, 8'hA0);
            rd(8'h4F, v);
            chk(v, {7'h00, f[1]});
            rd(8'h54, v);
            chk(v, {s[2], 1'b0, s[0], 3'h0, f[0], 1'b0});
            rd(8'h5B, v);
            chk(v, {s[1], 7'h00});
        end
    endtask

    // last capture had first strap 0 and second strap 7; now move both pins
    task automatic t_hold;
        firstRow = 2'h3;
        secondRow = 3'h0;
        repeat (30) @(negedge core_clk);
        chk(fields, 8'h07);
    endtask

    task automatic t_override;
        logic [7:0] v;
        wr(8'h4F, 8'hFF);
        wr(8'h54, 8'h5E);
        wr(8'h5B, 8'h7F);
        chk(fields, 8'h18);
        rd(8'h4F, v);
        chk(v, 8'hFF);
        rd(8'h54, v);
        chk(v, 8'h5E);
        rd(8'h5B, v);
        chk(v, 8'h7F);
        wr(8'h03, 8'h5A);
        chk(remAddr, 8'h5A);
    endtask

    // unmapped place and a foreign target address leave everything alone
    task automatic t_refuse;
        logic [7:0] v;
        logic a;
        wr(8'h40, 8'h77);
        rd(8'h40, v);
        chk(v, 8'h00);
        busStart;
        sendByte(8'h22, a);
        chk({7'h00, a}, 8'h00);
        busStop;
        chk(fields, 8'h18);
    endtask

    initial begin
        t_capture;
        t_hold;
        t_override;
        t_refuse;
        end_of_test;
    end

    // the whole sequence needs about 22k cycles; this allows 50k, over twice that
    initial begin
        #1000000;
        miscompares++;
        end_of_test;
    end
endmodule

bind mode_strap_config_latch strap_config_properties strap_config_properties_inst (.core_clk(core_clk),
    .nrst(nrst), .firstStrapInput(firstStrapInput), .secondStrapInput(secondStrapInput), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .displayIdSourceSelect(displayIdSourceSelect),
    .auxAudioSelect(auxAudioSelect), .externalControllerOverride(externalControllerOverride),
    .cableKindSelect(cableKindSelect), .remoteDisplayIdLoad(remoteDisplayIdLoad),
    .remoteTableAddr(remoteTableAddr), .configLoaded(configLoaded));

`default_nettype wire
